//--- ssl_speed_loop.sv
`timescale 1ns/1ps
`include "ssl_cfg.svh"
module ssl_speed_loop
   import ssl_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire ssl_preq_s   preq,
   output logic [15:0]      prd_data,
   output logic             prd_valid,
   input  wire ssl_gate_s   gate,
   input  wire logic [15:0] ain_one,
   input  wire logic [15:0] ain_two,
   input  wire logic [15:0] speed_fb,
   input  wire logic [15:0] position_loop_speed_demand,
   input  wire logic        ctl_tick,
   output logic [15:0]      current_demand,
   output logic             torque_mode
);
   logic [15:0]        offset_pair;
   logic [15:0]        cutoff_pair;
   logic [15:0]        scale_pair;
   logic [15:0]        dspeed;
   logic [15:0]        dtorq;
   logic [15:0]        filt;
   logic [15:0]        skp;
   logic [15:0]        sti;
   logic [15:0]        std_t;
   logic [15:0]        stim;
   logic [15:0]        refoff;
   logic [15:0]        reso;
   logic [15:0]        hspd;
   logic [15:0]        hloop;
   logic [15:0]        hramp;
   logic [15:0]        tol;
   logic [15:0]        ckp;
   logic [15:0]        cti;
   logic [15:0]        ctd;
   logic [15:0]        ctim;
   logic [15:0]        racc;
   logic [15:0]        rdec;
   logic [15:0]        raccn;
   logic [15:0]        rdecn;
   logic [15:0]        rlim;
   logic [15:0]        nlim;
   logic [15:0]        nlimp;
   logic [15:0]        nlimn;
   logic [15:0]        mode;
   logic [15:0]        nmax;
   logic [15:0]        ain1_raw;
   logic [15:0]        ain2_raw;
   logic [15:0]        ain1_int;
   logic [15:0]        ain2_int;
   logic [15:0]        meas;
   logic [15:0]        ramped;
   logic [15:0]        dev;
   logic [15:0]        disp;
   logic signed [31:0] integ;
   logic signed [31:0] fstate;
   logic signed [15:0] prev_dev;

   function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
      if (v > 32'sd32767)
         return 16'sh7fff;
      else if (v < -32'sd32767)
         return 16'sh8001;
      else
         return v[15:0];
   endfunction

   // Byte of a pair with a signed conditioning step
   function automatic logic signed [15:0] cond(input logic [15:0] raw,
         input logic [7:0] off, input logic [7:0] cut, input logic [7:0] scl);
      logic signed [31:0] t;
      t = 32'($signed(raw)) - 32'($signed(off));
      if (t < 32'($signed({8'h00, cut})) && t > -32'($signed({8'h00, cut})))
         t = 32'sd0;
      t = (t * 32'($signed({8'h00, scl}))) >>> 3;
      return sat16(t);
   endfunction

   function automatic logic [15:0] clampu(input logic [15:0] v,
         input logic [15:0] lo, input logic [15:0] hi);
      if (v < lo)
         return lo;
      else if (v > hi)
         return hi;
      else
         return v;
   endfunction

   // Parameter writes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         offset_pair <= 16'h0000;
         cutoff_pair <= 16'h0000;
         scale_pair <= `SSL_SCALE_RST;
         dspeed <= 16'h0000;
         dtorq <= 16'h0000;
         filt <= 16'h0000;
         skp <= 16'h0000;
         sti <= 16'h0000;
         std_t <= 16'h0000;
         stim <= 16'h0000;
         refoff <= 16'h0000;
         reso <= 16'h0000;
         hspd <= `SSL_HSPD_RST;
         hloop <= `SSL_HLOOP_RST;
         hramp <= 16'h0000;
         tol <= `SSL_TOL_RST;
         ckp <= `SSL_CKP_RST;
         cti <= `SSL_CTI_RST;
         ctd <= `SSL_CTD_RST;
         ctim <= `SSL_CTIM_RST;
         racc <= `SSL_RAMP_RST;
         rdec <= `SSL_RAMP_RST;
         raccn <= `SSL_RAMP_RST;
         rdecn <= `SSL_RAMP_RST;
         rlim <= `SSL_RLIM_RST;
         nlim <= `SSL_FULL;
         nlimp <= `SSL_FULL;
         nlimn <= `SSL_FULL;
         mode <= 16'h0000;
         nmax <= `SSL_NMAX_RST;
      end else if (preq.wr) begin
         unique case (preq.addr)
            `SSL_A_OFFSET:   offset_pair <= preq.data;
            `SSL_A_CUTOFF:   cutoff_pair <= preq.data;
            `SSL_A_SCALE:    scale_pair <= preq.data;
            `SSL_A_DSPEED:   dspeed <= preq.data;
            `SSL_A_DTORQ:    dtorq <= preq.data;
            `SSL_A_FILTER:   filt <= clampu(preq.data, 16'h0000, `SSL_FILT_MAX);
            `SSL_A_SKP:      skp <= preq.data;
            `SSL_A_STI:      sti <= preq.data;
            `SSL_A_STD:      std_t <= preq.data;
            `SSL_A_STIM:     stim <= clampu(preq.data, 16'h0000, `SSL_CTIM_MAX);
            `SSL_A_REFOFF:   refoff <= preq.data;
            `SSL_A_RESO:     reso <= preq.data;
            `SSL_A_HSPD:     hspd <= clampu(preq.data, `SSL_HSPD_MIN, `SSL_HSPD_MAX);
            `SSL_A_HLOOP:    hloop <= preq.data;
            `SSL_A_HRAMP:    hramp <= {15'h0000, preq.data[0]};
            `SSL_A_TOL:      tol <= clampu(preq.data, 16'h0000, `SSL_TOL_MAX);
            `SSL_A_CKP:      ckp <= preq.data;
            `SSL_A_CTI:      cti <= preq.data;
            `SSL_A_CTD:      ctd <= preq.data;
            `SSL_A_CTIM:     ctim <= clampu(preq.data, 16'h0000, `SSL_CTIM_MAX);
            `SSL_A_RAMPACC:  racc <= preq.data;
            `SSL_A_RAMPDEC:  rdec <= preq.data;
            `SSL_A_RAMPACCN: raccn <= preq.data;
            `SSL_A_RAMPDECN: rdecn <= preq.data;
            `SSL_A_RAMPLIM:  rlim <= preq.data;
            `SSL_A_NLIM:     nlim <= preq.data;
            `SSL_A_NLIMP:    nlimp <= preq.data;
            `SSL_A_NLIMN:    nlimn <= preq.data;
            `SSL_A_MODE:     mode <= {13'h0000, preq.data[2:0]};
            `SSL_A_NMAX:     nmax <= preq.data;
            default: ;
         endcase
      end
   end

   // Analog conditioning, high byte for input one, low byte for input two
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ain1_raw <= 16'h0000;
         ain2_raw <= 16'h0000;
         ain1_int <= 16'h0000;
         ain2_int <= 16'h0000;
      end else begin
         ain1_raw <= ain_one;
         ain2_raw <= ain_two;
         ain1_int <= cond(ain1_raw, offset_pair[15:8], cutoff_pair[15:8], scale_pair[15:8]);
         ain2_int <= cond(ain2_raw, offset_pair[7:0], cutoff_pair[7:0], scale_pair[7:0]);
      end
   end

   // Demand selection, sum and gating
   logic signed [15:0] dig_dem;
   logic signed [15:0] ana_dem;
   logic signed [15:0] sum_dem;
   logic signed [15:0] gated;
   logic signed [15:0] ramp_in;
   logic [15:0]        stepv;
   logic signed [15:0] lo_lim;
   logic signed [15:0] hi_lim;
   always_comb begin
      unique case (mode[1:0])
         `SSL_MODE_TRQ: dig_dem = dtorq;
         `SSL_MODE_POS: dig_dem = position_loop_speed_demand;
         default:       dig_dem = dspeed;
      endcase
      ana_dem = ain1_int;
      // Saturating sum guards against a demand pair left too large
      sum_dem = sat16(32'(gate.sel_analog ? ana_dem : 16'sd0)
                    + 32'(gate.sel_digital ? dig_dem : 16'sd0));
      gated = (gate.en && gate.go) ? sum_dem : 16'sd0;
      ramp_in = (gate.en && gate.lim_pos && gate.lim_neg && !gate.zero_speed
                 && !gate.brake) ? gated : 16'sd0;
      hi_lim = $signed(nlimp < nlim ? nlimp : nlim);
      lo_lim = -$signed(nlimn < nlim ? nlimn : nlim);
      // Ramp step: limit ramp when stop is forced, else by direction
      if (!(gate.lim_pos && gate.lim_neg) || gate.brake)
         stepv = rlim;
      else if (($signed(ramp_in) > $signed(ramped)) == !ramped[15] || ramped == 16'h0000)
         // Moving away from zero: the target's sign gives the direction, also from standstill
         stepv = (mode[2] && ramp_in[15]) ? raccn : racc;
      else
         stepv = (mode[2] && ramped[15]) ? rdecn : rdec;
   end

   // Ramp stage, one step per control tick
   always_ff @(posedge clk_sys) begin
      logic signed [31:0] tgt;
      logic signed [31:0] nxt;
      logic signed [31:0] stp;
      if (rst) begin
         ramped <= 16'h0000;
      end else if (ctl_tick) begin
         tgt = 32'(ramp_in);
         if (tgt > 32'(hi_lim)) tgt = 32'(hi_lim);
         if (tgt < 32'(lo_lim)) tgt = 32'(lo_lim);
         nxt = 32'($signed(ramped));
         // Step kept signed so that comparisons below zero stay signed
         stp = 32'($signed({1'b0, stepv}));
         if (tgt > nxt + stp) nxt = nxt + stp;
         else if (tgt < nxt - stp) nxt = nxt - stp;
         else nxt = tgt;
         ramped <= sat16(nxt);
      end
   end

   // Feedback filter, deviation and display value
   always_ff @(posedge clk_sys) begin
      logic signed [31:0] d;
      if (rst) begin
         fstate <= 32'sd0;
         meas <= 16'h0000;
         dev <= 16'h0000;
         disp <= 16'h0000;
      end else if (ctl_tick) begin
         d = (32'($signed(speed_fb)) <<< 16) - fstate;
         fstate <= fstate + (d >>> filt[3:0]);
         meas <= fstate[31:16];
         dev <= sat16(32'($signed(ramped)) - 32'($signed(meas)));
         disp <= 16'((32'($signed(meas)) * 32'($signed({1'b0, nmax}))) >>> 15);
      end
   end

   // Speed PID with clamped integral memory
   logic signed [31:0] ilim;
   assign ilim = (32'sd32767 * 32'(ctim)) / 32'sd100;
   always_ff @(posedge clk_sys) begin
      logic signed [31:0] acc;
      logic signed [31:0] pterm;
      logic signed [31:0] dterm;
      if (rst) begin
         integ <= 32'sd0;
         prev_dev <= 16'sd0;
         current_demand <= 16'h0000;
      end else if (ctl_tick) begin
         acc = integ;
         // Gains are widened with a zero sign bit so negative deviations stay signed
         if (sti != 16'h0000)
            acc = integ + 32'($signed(dev)) / 32'($signed({1'b0, sti}));
         if (acc > ilim) acc = ilim;
         if (acc < -ilim) acc = -ilim;
         integ <= acc;
         prev_dev <= dev;
         pterm = (32'($signed(dev)) * 32'($signed({1'b0, skp}))) >>> 4;
         dterm = ((32'($signed(dev)) - 32'(prev_dev)) * 32'($signed({1'b0, std_t}))) >>> 4;
         if (mode[1:0] == `SSL_MODE_TRQ)
            current_demand <= ramped;
         else
            current_demand <= sat16(pterm + acc + dterm);
      end
   end
   assign torque_mode = (mode[1:0] == `SSL_MODE_TRQ);

   // Parameter reads
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prd_data <= 16'h0000;
         prd_valid <= 1'b0;
      end else begin
         prd_valid <= preq.rd;
         unique case (preq.addr)
            `SSL_A_OFFSET:   prd_data <= offset_pair;
            `SSL_A_MEAS:     prd_data <= meas;
            `SSL_A_DSPEED:   prd_data <= dspeed;
            `SSL_A_RAMPED:   prd_data <= ramped;
            `SSL_A_ERROR:    prd_data <= dev;
            `SSL_A_CUTOFF:   prd_data <= cutoff_pair;
            `SSL_A_SCALE:    prd_data <= scale_pair;
            `SSL_A_FILTER:   prd_data <= filt;
            `SSL_A_SKP:      prd_data <= skp;
            `SSL_A_STI:      prd_data <= sti;
            `SSL_A_STD:      prd_data <= std_t;
            `SSL_A_STIM:     prd_data <= stim;
            `SSL_A_REFOFF:   prd_data <= refoff;
            `SSL_A_RESO:     prd_data <= reso;
            `SSL_A_HSPD:     prd_data <= hspd;
            `SSL_A_HLOOP:    prd_data <= hloop;
            `SSL_A_HRAMP:    prd_data <= hramp;
            `SSL_A_TOL:      prd_data <= tol;
            `SSL_A_DTORQ:    prd_data <= dtorq;
            `SSL_A_DISP:     prd_data <= disp;
            `SSL_A_CKP:      prd_data <= ckp;
            `SSL_A_CTI:      prd_data <= cti;
            `SSL_A_CTD:      prd_data <= ctd;
            `SSL_A_CTIM:     prd_data <= ctim;
            `SSL_A_AIN1:     prd_data <= {ain1_int[15:8], ain1_raw[7:0]};
            `SSL_A_AIN2:     prd_data <= {ain2_int[15:8], ain2_raw[7:0]};
            `SSL_A_RAMPACC:  prd_data <= racc;
            `SSL_A_RAMPDEC:  prd_data <= rdec;
            `SSL_A_RAMPACCN: prd_data <= raccn;
            `SSL_A_RAMPDECN: prd_data <= rdecn;
            `SSL_A_RAMPLIM:  prd_data <= rlim;
            `SSL_A_NLIM:     prd_data <= nlim;
            `SSL_A_NLIMP:    prd_data <= nlimp;
            `SSL_A_NLIMN:    prd_data <= nlimn;
            `SSL_A_MODE:     prd_data <= mode;
            `SSL_A_NMAX:     prd_data <= nmax;
            default:         prd_data <= 16'h0000;
         endcase
      end
   end

   // Checks
   a_gate_zero: assert property (@(posedge clk_sys) disable iff (rst)
      !(gate.en && gate.go) |-> gated == 16'sd0) else $error("ungated setpoint");
   a_ramp_block: assert property (@(posedge clk_sys) disable iff (rst)
      gate.brake |-> ramp_in == 16'sd0) else $error("ramp fed under brake");
   a_ramp_clamp: assert property (@(posedge clk_sys) disable iff (rst)
      ctl_tick && hi_lim >= 16'sd0 && $stable(hi_lim) |=> $signed(ramped) <= $past(hi_lim)
      || $signed($past(ramped)) > $past(hi_lim)) else $error("clamp exceeded");
   a_limit_ramp: assert property (@(posedge clk_sys) disable iff (rst)
      ctl_tick && !gate.lim_pos && $signed(ramped) > $signed({1'b0, rlim}) |=>
      $signed(ramped) == $signed($past(ramped)) - $signed({1'b0, $past(rlim)}))
      else $error("limit ramp not applied");
   a_torque_pass: assert property (@(posedge clk_sys) disable iff (rst)
      ctl_tick && torque_mode |=> current_demand == $past(ramped))
      else $error("torque bypass wrong");
   a_dev_calc: assert property (@(posedge clk_sys) disable iff (rst)
      ctl_tick |=> dev == sat16(32'($signed($past(ramped))) - 32'($signed($past(meas)))))
      else $error("deviation wrong");
   a_integ_lim: assert property (@(posedge clk_sys) disable iff (rst)
      ctl_tick |=> integ <= $past(ilim) && integ >= -$past(ilim))
      else $error("integral over limit");
   a_ctim_range: assert property (@(posedge clk_sys) disable iff (rst)
      ctim <= `SSL_CTIM_MAX) else $error("limit out of range");
   a_hspd_range: assert property (@(posedge clk_sys) disable iff (rst)
      hspd >= `SSL_HSPD_MIN && hspd <= `SSL_HSPD_MAX) else $error("speed out of range");
   a_tol_range: assert property (@(posedge clk_sys) disable iff (rst)
      tol <= `SSL_TOL_MAX) else $error("window out of range");
   a_sum_sat: assert property (@(posedge clk_sys) disable iff (rst)
      sum_dem != 16'sh8000) else $error("sum wrapped");
   a_demand_sat: assert property (@(posedge clk_sys) disable iff (rst)
      current_demand != 16'h8000) else $error("demand wrapped");
   c_torque: cover property (@(posedge clk_sys) ctl_tick && torque_mode);
   c_four_ramp: cover property (@(posedge clk_sys) ctl_tick && mode[2] && ramped[15]);
   c_both_src: cover property (@(posedge clk_sys) gate.sel_analog && gate.sel_digital);
   c_limit_stop: cover property (@(posedge clk_sys) ctl_tick && !gate.lim_pos);
   c_integ_sat: cover property (@(posedge clk_sys) integ == ilim && ilim != 0);
endmodule

//--- ssl_cfg.svh
// How it works
// - Each analog input gets offset, cutoff and scale; processed high byte and raw low byte readable.
// - With both sources selected, analog and digital demands are summed.
// - Digital demand comes from speed value, torque value or position controller.
// - Digital speed setpoint at 0x31, digital torque setpoint at 0x90.
// - Setpoint passes only with drive enable and internal release; else zero.
// - Ramp input needs enable, both limit switches, no zero-speed, no brake.
// - Ramp applies accel, decel, limit ramp and overall, positive, negative clamps.
// - Torque mode uses the ramped setpoint as torque demand, bypassing PID.
// - Measured speed is low-pass filtered by the parameter at 0x5e.
// - Deviation is ramped setpoint minus filtered speed, and is readable.
// - PID with gain, integral time, derivative time and integral limit.
// - Position-current integral limit 0..100 percent, default 50, at 0xcd.
// - Homing approach speed 10..32000, default 3000, at 0x76.
// - Homing deceleration selects acceleration ramp or limit ramp, at 0x78; only bit 0 is stored, and only the parameter read uses it.
// - Position tolerance window 0..2000, default 100, at 0x79.
// - Configured maximum speed maps to full scale 32767.
// - Two ramps for both directions, or four ramps by direction.
`ifndef SSL_CFG_SVH
`define SSL_CFG_SVH
`define SSL_A_OFFSET    8'h2f
`define SSL_A_MEAS      8'h30
`define SSL_A_DSPEED    8'h31
`define SSL_A_RAMPED    8'h32
`define SSL_A_ERROR     8'h33
`define SSL_A_CUTOFF    8'h50
`define SSL_A_SCALE     8'h53
`define SSL_A_FILTER    8'h5e
`define SSL_A_SKP       8'h6a
`define SSL_A_STI       8'h6b
`define SSL_A_STD       8'h6c
`define SSL_A_STIM      8'h71
`define SSL_A_REFOFF    8'h72
`define SSL_A_RESO      8'h75
`define SSL_A_HSPD      8'h76
`define SSL_A_HLOOP     8'h77
`define SSL_A_HRAMP     8'h78
`define SSL_A_TOL       8'h79
`define SSL_A_DTORQ     8'h90
`define SSL_A_DISP      8'ha8
`define SSL_A_CKP       8'hc9
`define SSL_A_CTI       8'hca
`define SSL_A_CTD       8'hcb
`define SSL_A_CTIM      8'hcd
`define SSL_A_AIN1      8'hd5
`define SSL_A_AIN2      8'hd6
`define SSL_A_RAMPACC   8'he0
`define SSL_A_RAMPDEC   8'he1
`define SSL_A_RAMPACCN  8'he2
`define SSL_A_RAMPDECN  8'he3
`define SSL_A_RAMPLIM   8'he4
`define SSL_A_NLIM      8'he5
`define SSL_A_NLIMP     8'he6
`define SSL_A_NLIMN     8'he7
`define SSL_A_MODE      8'he8
`define SSL_A_NMAX      8'he9
`define SSL_FULL        16'h7fff
`define SSL_NFULL       16'h8001
`define SSL_CTIM_RST    16'h0032
`define SSL_SCALE_RST   16'h0808
`define SSL_HLOOP_RST   16'h01f4
`define SSL_CKP_RST     16'h0032
`define SSL_CTI_RST     16'h012c
`define SSL_CTD_RST     16'h1388
`define SSL_RAMP_RST    16'h0100
`define SSL_RLIM_RST    16'h0400
`define SSL_NMAX_RST    16'h0bb8
`define SSL_CTIM_MAX    16'h0064
`define SSL_HSPD_RST    16'h0bb8
`define SSL_HSPD_MIN    16'h000a
`define SSL_HSPD_MAX    16'h7d00
`define SSL_TOL_RST     16'h0064
`define SSL_TOL_MAX     16'h07d0
`define SSL_FILT_MAX    16'h000a
`define SSL_MODE_SPD    2'h0
`define SSL_MODE_TRQ    2'h1
`define SSL_MODE_POS    2'h2
`endif

//--- ssl_pkg.sv
package ssl_pkg;
   typedef struct packed {
      logic        en;
      logic        go;
      logic        lim_pos;
      logic        lim_neg;
      logic        zero_speed;
      logic        brake;
      logic        sel_analog;
      logic        sel_digital;
   } ssl_gate_s;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] data;
   } ssl_preq_s;
   typedef enum logic [1:0] {SSL_SRC_SPEED, SSL_SRC_TORQUE, SSL_SRC_POS} ssl_src_e;
endpackage

//--- ssl_motor_model.sv
`timescale 1ns/1ps
module ssl_motor_model #(
   parameter int GAIN_SHIFT = 6,
   parameter int SPEED_MAX  = 8192
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        ctl_tick,
   input  wire logic [15:0] current_demand,
   input  wire logic        stall,
   output logic [15:0]      speed_fb
);
   logic signed [31:0] speed;
   logic signed [31:0] next_speed;

   // Rotor accelerates with demand and loses a sixteenth of its speed to friction; bounded mechanical speed
   always_comb begin
      next_speed = speed + ($signed(current_demand) >>> GAIN_SHIFT) - (speed >>> 4);
      if (next_speed > SPEED_MAX) begin
         next_speed = SPEED_MAX;
      end else if (next_speed < -SPEED_MAX) begin
         next_speed = -SPEED_MAX;
      end
   end

   // A stalled rotor holds its speed so the bench can freeze the feedback
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         speed <= '0;
      end else if (ctl_tick && !stall) begin
         speed <= next_speed;
      end
   end

   assign speed_fb = speed[15:0];
endmodule

//--- ssl_speed_loop_test.sv
`timescale 1ns/1ps
module ssl_speed_loop_test
   import ssl_pkg::*;
;
   localparam ssl_gate_s GATE_OK = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   logic        clk_sys;
   logic        rst;
   ssl_preq_s   preq;
   logic [15:0] prd_data;
   logic        prd_valid;
   ssl_gate_s   gate;
   logic [15:0] ain_one;
   logic [15:0] ain_two;
   logic [15:0] speed_fb;
   logic [15:0] position_loop_speed_demand;
   logic        ctl_tick;
   logic [15:0] current_demand;
   logic        torque_mode;
   logic        stall;
   int          miscompares;
   int          samples_checked;
   logic [15:0] rd_val;

   ssl_speed_loop dut (.clk_sys(clk_sys), .rst(rst), .preq(preq), .prd_data(prd_data),
      .prd_valid(prd_valid), .gate(gate), .ain_one(ain_one), .ain_two(ain_two),
      .speed_fb(speed_fb), .position_loop_speed_demand(position_loop_speed_demand),
      .ctl_tick(ctl_tick), .current_demand(current_demand), .torque_mode(torque_mode));

   ssl_motor_model motor (.clk_sys(clk_sys), .rst(rst), .ctl_tick(ctl_tick),
      .current_demand(current_demand), .stall(stall), .speed_fb(speed_fb));

   // Free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Compare one value and count it
   task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
      samples_checked++;
      if (seen !== want) begin
         miscompares++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, want);
      end
   endtask

   // Print the counts and the verdict, then stop
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Expected register contents after a write, with range limits applied
   function automatic logic [15:0] exp_wr(input logic [7:0] a, input logic [15:0] d);
      int v;
      v = d;
      case (a)
         8'h76: v = (v < 10) ? 10 : (v > 32000) ? 32000 : v;
         8'h79: v = (v > 2000) ? 2000 : v;
         8'hcd, 8'h71: v = (v > 100) ? 100 : v;
         8'h5e: v = (v > 10) ? 10 : v;
         8'h78: v = v & 1;
         default: ;
      endcase
      return v[15:0];
   endfunction

   // One-cycle write strobe
   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      #10;
      preq = '{1'b1, 1'b0, a, d};
      @(posedge clk_sys);
      #10;
      preq.wr = 1'b0;
   endtask

   // One-cycle read strobe; data and valid arrive one cycle later
   task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk_sys);
      #10;
      preq = '{1'b0, 1'b1, a, 16'h0000};
      @(posedge clk_sys);
      #10;
      preq.rd = 1'b0;
      check({15'h0000, prd_valid}, 16'h0001, "read valid");
      v = prd_data;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] want, input string what);
      reg_rd(a, rd_val);
      check(rd_val, want, what);
   endtask

   // Control-rate enable pulses
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         #10;
         ctl_tick = 1'b1;
         @(posedge clk_sys);
         #10;
         ctl_tick = 1'b0;
      end
   endtask

   // Saturated demand must never show the wrapped negative extreme
   always @(negedge clk_sys) begin
      if (!rst && current_demand === 16'h8000) begin
         check(current_demand, 16'h8001, "demand wrapped");
      end
   end

   // Hang guard, well beyond the expected run
   initial begin
      #(20000 * 100);
      miscompares++;
      print_verdict();
   end

   // Main sequence
   initial begin
      logic [7:0]  ra [7] = '{8'h76, 8'h79, 8'hcd, 8'hc9, 8'hca, 8'hcb, 8'h77};
      logic [15:0] rv [7] = '{16'h0bb8, 16'h0064, 16'h0032, 16'h0032, 16'h012c, 16'h1388, 16'h01f4};
      logic [7:0]  wa [10] = '{8'h31, 8'h90, 8'h76, 8'h76, 8'h79, 8'hcd, 8'h71, 8'h78, 8'h5e, 8'h72};
      logic [15:0] wd [10];
      logic [15:0] src [3];
      int          p1;
      int          fb;
      rst = 1'b1;
      preq = '0;
      gate = GATE_OK;
      ain_one = 16'h0000;
      ain_two = 16'h0000;
      position_loop_speed_demand = 16'h0c00;
      ctl_tick = 1'b0;
      stall = 1'b0;
      void'($urandom(5981));
      repeat (6) @(posedge clk_sys);
      #10;
      rst = 1'b0;
      check(current_demand, 16'h0000, "demand after reset");
      for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i], "reset value");
      $display("test reset values done");
      wd = '{16'($urandom_range(0, 32767)), 16'($urandom_range(0, 32767)), 16'h0005, 16'h7fff,
         16'h0bb8, 16'h00c8, 16'h0096, 16'h0003, 16'h0014, 16'($urandom_range(0, 32767))};
      for (int i = 0; i < 10; i++) begin
         reg_wr(wa[i], wd[i]);
         rd_chk(wa[i], exp_wr(wa[i], wd[i]), "parameter access");
      end
      reg_wr(8'h01, 16'h1234);
      rd_chk(8'h01, 16'h0000, "unmapped read");
      $display("test parameter access done");
      reg_wr(8'h2f, 16'h1002);
      reg_wr(8'h50, 16'h0000);
      reg_wr(8'h53, 16'h1008);
      reg_wr(8'h5e, 16'h0000);
      ain_one = 16'($urandom_range(16'h0100, 16'h01ff));
      ain_two = 16'($urandom_range(16'h0100, 16'h01ff));
      tick(3);
      p1 = (ain_one - 16) * 2;
      rd_chk(8'hd5, {p1[15:8], ain_one[7:0]}, "analog one");
      rd_chk(8'hd6, {ain_two[15:8] - 8'(ain_two[7:0] < 2), ain_two[7:0]}, "analog two");
      $display("test analog conditioning done");
      reg_wr(8'h31, 16'h0600);
      reg_wr(8'h90, 16'h0a00);
      src = '{16'h0600, 16'h0a00, 16'h0c00};
      for (int m = 0; m < 3; m++) begin
         reg_wr(8'he8, 16'(m));
         tick(40);
         rd_chk(8'h32, src[m], "digital source");
         check({15'h0000, torque_mode}, 16'(m == 1), "torque mode flag");
         if (m == 1) check(current_demand, src[1], "torque bypass");
      end
      reg_wr(8'he8, 16'h0000);
      gate.sel_analog = 1'b1;
      tick(40);
      rd_chk(8'h32, 16'(p1 + 'h600), "analog plus digital");
      gate.sel_digital = 1'b0;
      tick(40);
      rd_chk(8'h32, 16'(p1), "analog only");
      $display("test source selection done");
      for (int k = 0; k < 6; k++) begin
         gate = GATE_OK;
         tick(40);
         rd_chk(8'h32, 16'h0600, "released setpoint");
         case (k)
            0: gate.en = 1'b0;
            1: gate.go = 1'b0;
            2: gate.lim_pos = 1'b0;
            3: gate.lim_neg = 1'b0;
            4: gate.zero_speed = 1'b1;
            default: gate.brake = 1'b1;
         endcase
         tick(40);
         rd_chk(8'h32, 16'h0000, "blocked setpoint");
      end
      gate = GATE_OK;
      $display("test gating done");
      reg_wr(8'he6, 16'h0400);
      tick(40);
      rd_chk(8'h32, 16'h0400, "positive clamp");
      reg_wr(8'he6, 16'h7fff);
      reg_wr(8'he5, 16'h0200);
      tick(40);
      rd_chk(8'h32, 16'h0200, "overall clamp");
      reg_wr(8'he5, 16'h7fff);
      reg_wr(8'he7, 16'h0300);
      reg_wr(8'he8, 16'h0002);
      position_loop_speed_demand = 16'hf800;
      tick(40);
      rd_chk(8'h32, 16'hfd00, "negative clamp");
      reg_wr(8'he7, 16'h7fff);
      reg_wr(8'he8, 16'h0000);
      $display("test speed clamps done");
      gate.en = 1'b0;
      tick(8);
      reg_wr(8'he2, 16'h0040);
      reg_wr(8'he8, 16'h0006);
      position_loop_speed_demand = 16'hfc00;
      gate.en = 1'b1;
      tick(2);
      rd_chk(8'h32, 16'hff80, "four-ramp negative accel");
      reg_wr(8'he8, 16'h0000);
      $display("test four ramps done");
      tick(40);
      stall = 1'b1;
      tick(5);
      fb = $signed(speed_fb);
      rd_chk(8'h30, speed_fb, "measured speed");
      rd_chk(8'h33, 16'(32'h600 - fb), "speed deviation");
      rd_chk(8'ha8, 16'((fb * 3000) >>> 15), "display speed");
      reg_wr(8'h6a, 16'h0010);
      tick(2);
      check(current_demand, 16'(32'h600 - fb), "proportional demand");
      reg_wr(8'hcd, 16'h0001);
      reg_wr(8'h6b, 16'h0002);
      tick(3);
      check(current_demand, 16'(32'h600 - fb + 32767 / 100), "integral limit");
      stall = 1'b0;
      $display("test feedback path done");
      print_verdict();
   end
endmodule
